// ===== src/ssm_pkg.sv
// package: constants for the supply switchover monitor
// Notes on behaviour
// - switchover on after reset; config bit 1 keeps main supply always
// - peripheral config bit 6 reads one on main supply, zero on battery
// - low dc input moves to battery only when select field is clear
// - main supply low moves to battery while select upper bit is clear
// - pin function 0bx01 lets rising request pin edge force battery
// - return to main only once every enabled condition is false
// - return waits for recovered voltages over the qualification time
// - with request pin enabled, return also needs the pin low
// - monitor interrupt off after reset, gated by global enable bit
// - per-source enable register picks events for the shared interrupt
// - event flags latch until software clears them in flag register
// - main-to-battery change sets switchover flag; enable bit 1 gates its interrupt
// - battery-to-main change sets restore flag; switchover enable bit 1 gates its interrupt
// - switchover and restore flags set regardless of enables
// - writing zero clears switchover and restore flags, one leaves them
// - switched supply change beyond programmed delta raises event
// - periodic background measurements plus immediate one on start write
// - switched supply monitor flag also set on every new result
// - battery flag on result below threshold or on new result
// - dc input flag set while comparator reports input low
// - sag flag set on sag indication; sag enable gates its interrupt
// - enable bits: sag 5, supply 3, battery 2, switchover 1, dc 0
package ssm_pkg;
   localparam logic [7:0] ADDR_IE_PRIO_TWO = 8'h00a9;
   localparam logic [7:0] ADDR_ADC_START = 8'h00d8;
   localparam logic [7:0] ADDR_BAT_RESULT = 8'h00df;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h00ec;
   localparam logic [7:0] ADDR_DELTA = 8'h00f3;
   localparam logic [7:0] ADDR_PERIPHERAL_CONFIG_CFG = 8'h00f4;
   localparam logic [7:0] ADDR_SWO_CFG = 8'h00f5;
   localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h00f8;
   localparam logic [7:0] ADDR_BAT_THRESH = 8'h00fa;
   localparam logic [7:0] ADDR_INT_PIN_CFG = 8'h00ff;
   // bit positions
   localparam int BIT_GLOBAL_EN = 5;
   localparam int BIT_SWO_DISABLE = 1;
   localparam int BIT_SEL_LO = 2;
   localparam int BIT_SEL_HI = 3;
   localparam int BIT_SOURCE = 6;
   localparam int BIT_SAG = 5;
   localparam int BIT_RSV = 4;
   localparam int BIT_VSW = 3;
   localparam int BIT_BAT = 2;
   localparam int BIT_SWO = 1;
   localparam int BIT_DC = 0;
   localparam int BIT_RESTORE = 6;
   localparam int BIT_PINFN_LO = 2;
   localparam int BIT_PINFN_HI = 3;
   localparam logic [1:0] PINFN_BATTERY = 2'b01;
   // reset values
   localparam logic [7:0] RST_ZERO = 8'h0000;
   localparam logic [7:0] RST_SELECT = 8'h000c;
   localparam logic [7:0] ENABLE_MASK = 8'h006f;
   localparam logic [7:0] FLAG_MASK = 8'h007f;
   // timing
   localparam int QUAL_TIME_US = 1000;
   localparam int CLK_MHZ = 50;
   localparam int QUAL_CYCLES = QUAL_TIME_US * CLK_MHZ;
   localparam int MEAS_PERIOD_US = 1000;
   localparam int MEAS_CYCLES = MEAS_PERIOD_US * CLK_MHZ;
endpackage

// ===== src/ssm_supply_monitor.sv
// module: supply switchover control and shared monitor interrupt
`timescale 1ns/1ps
`default_nettype none
module ssm_supply_monitor
#(
   parameter int QUAL_COUNT = ssm_pkg::QUAL_CYCLES,
   parameter int MEAS_COUNT = ssm_pkg::MEAS_CYCLES
)
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_write,
   input wire logic sfr_read,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic main_low,
   input wire logic main_recovered,
   input wire logic dc_input_low,
   input wire logic dc_input_recovered,
   input wire logic battery_request_pin,
   input wire logic line_sag_event,
   input wire logic vsw_result_valid,
   input wire logic [7:0] vsw_result,
   input wire logic bat_result_valid,
   input wire logic [7:0] bat_result,
   output logic use_battery,
   output logic supply_monitor_interrupt,
   output logic conversion_start
);
   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [7:0] ie_prio_two;
   logic [7:0] irq_enable;
   logic [7:0] delta;
   logic [7:0] peripheral_config_cfg;
   logic [7:0] swo_cfg;
   logic [7:0] bat_thresh;
   logic [7:0] int_pin_cfg;
   logic [7:0] bat_latched;
   logic [7:0] vsw_last;
   logic [7:0] flags;
   logic [7:0] next_flags;
   logic pin_last;
   logic on_battery;
   logic [31:0] main_qual_cnt;
   logic [31:0] dc_qual_cnt;
   logic [31:0] meas_cnt;
   logic wr_en;
   logic sw_disabled;
   logic dc_enabled;
   logic main_enabled;
   logic pin_enabled;
   logic pin_rise;
   logic go_battery;
   logic main_good;
   logic dc_good;
   logic qualified;
   logic vsw_big_change;
   logic [7:0] vsw_diff;
   logic [7:0] set_mask;
   logic bat_low;
   logic vsw_change_event;

   assign wr_en = sfr_write;
   assign sw_disabled = swo_cfg[ssm_pkg::BIT_SWO_DISABLE];
   assign dc_enabled = ~swo_cfg[ssm_pkg::BIT_SEL_HI]
      & ~swo_cfg[ssm_pkg::BIT_SEL_LO];
   assign main_enabled = ~swo_cfg[ssm_pkg::BIT_SEL_HI];
   assign pin_enabled =
      int_pin_cfg[ssm_pkg::BIT_PINFN_HI:ssm_pkg::BIT_PINFN_LO]
      == ssm_pkg::PINFN_BATTERY;
   assign pin_rise = battery_request_pin & ~pin_last;
   assign go_battery = (dc_enabled & dc_input_low)
      | (main_enabled & main_low)
      | (pin_enabled & pin_rise);

   // ---------------------------------------------------------------
   // register writes
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         ie_prio_two <= ssm_pkg::RST_ZERO;
      else if (wr_en && sfr_addr == ssm_pkg::ADDR_IE_PRIO_TWO)
         ie_prio_two <= sfr_wdata;
   end

   // bit 4 is forced low to keep the reserved enable clear
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         irq_enable <= ssm_pkg::RST_ZERO;
      else if (wr_en && sfr_addr == ssm_pkg::ADDR_IRQ_ENABLE)
         irq_enable <= sfr_wdata & ssm_pkg::ENABLE_MASK;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         delta <= ssm_pkg::RST_ZERO;
      else if (wr_en && sfr_addr == ssm_pkg::ADDR_DELTA)
         delta <= sfr_wdata;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         peripheral_config_cfg <= ssm_pkg::RST_ZERO;
      else if (wr_en && sfr_addr == ssm_pkg::ADDR_PERIPHERAL_CONFIG_CFG)
         peripheral_config_cfg <= sfr_wdata;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         swo_cfg <= ssm_pkg::RST_SELECT;
      else if (wr_en && sfr_addr == ssm_pkg::ADDR_SWO_CFG)
         swo_cfg <= sfr_wdata;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         bat_thresh <= ssm_pkg::RST_ZERO;
      else if (wr_en && sfr_addr == ssm_pkg::ADDR_BAT_THRESH)
         bat_thresh <= sfr_wdata;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         int_pin_cfg <= ssm_pkg::RST_ZERO;
      else if (wr_en && sfr_addr == ssm_pkg::ADDR_INT_PIN_CFG)
         int_pin_cfg <= sfr_wdata;
   end

   // ---------------------------------------------------------------
   // pin edge and recovery qualification
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         pin_last <= 1'b0;
      else
         pin_last <= battery_request_pin;
   end

   // each enabled voltage must stay good on its own for the full interval;
   // a single glitch restarts only that voltage's count
   assign main_good = main_recovered
      & ~(main_enabled & main_low);
   assign dc_good = ~dc_enabled
      | (dc_input_recovered & ~dc_input_low);

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         main_qual_cnt <= 32'h0000_0000;
      else if (!on_battery || !main_good)
         main_qual_cnt <= 32'h0000_0000;
      else if (main_qual_cnt < 32'(QUAL_COUNT))
         main_qual_cnt <= main_qual_cnt + 32'h0000_0001;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         dc_qual_cnt <= 32'h0000_0000;
      else if (!on_battery || !dc_good)
         dc_qual_cnt <= 32'h0000_0000;
      else if (dc_qual_cnt < 32'(QUAL_COUNT))
         dc_qual_cnt <= dc_qual_cnt + 32'h0000_0001;
   end

   assign qualified = (main_qual_cnt >= 32'(QUAL_COUNT))
      & (dc_qual_cnt >= 32'(QUAL_COUNT))
      & ~(pin_enabled & battery_request_pin);

   // ---------------------------------------------------------------
   // supply source
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         on_battery <= 1'b0;
      else if (sw_disabled)
         on_battery <= 1'b0;
      else if (!on_battery && go_battery)
         on_battery <= 1'b1;
      else if (on_battery && qualified)
         on_battery <= 1'b0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         use_battery <= 1'b0;
      else
         use_battery <= on_battery;
   end

   // ---------------------------------------------------------------
   // measurements
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         meas_cnt <= 32'h0000_0000;
         conversion_start <= 1'b0;
      end
      else
      begin
         conversion_start <= 1'b0;
         if (meas_cnt >= 32'(MEAS_COUNT - 1))
         begin
            meas_cnt <= 32'h0000_0000;
            conversion_start <= 1'b1;
         end
         else
            meas_cnt <= meas_cnt + 32'h0000_0001;
         if (wr_en && sfr_addr == ssm_pkg::ADDR_ADC_START)
            conversion_start <= 1'b1;
      end
   end

   assign vsw_diff = (vsw_result > vsw_last) ? vsw_result - vsw_last
      : vsw_last - vsw_result;
   assign vsw_big_change = vsw_diff > delta;
   assign vsw_change_event = vsw_result_valid & vsw_big_change;
   // a latched result under the threshold keeps the flag raised
   assign bat_low = bat_latched < bat_thresh;

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         vsw_last <= ssm_pkg::RST_ZERO;
         bat_latched <= ssm_pkg::RST_ZERO;
      end
      else
      begin
         if (vsw_result_valid)
            vsw_last <= vsw_result;
         if (bat_result_valid)
            bat_latched <= bat_result;
      end
   end

   // ---------------------------------------------------------------
   // event flags; a set in the same cycle as a clear wins
   // ---------------------------------------------------------------
   always_comb
   begin
      set_mask = ssm_pkg::RST_ZERO;
      set_mask[ssm_pkg::BIT_SWO] = go_battery & ~on_battery
         & ~sw_disabled;
      set_mask[ssm_pkg::BIT_RESTORE] = on_battery
         & (qualified | sw_disabled);
      set_mask[ssm_pkg::BIT_VSW] = vsw_change_event
         | vsw_result_valid;
      set_mask[ssm_pkg::BIT_BAT] = bat_result_valid | bat_low;
      set_mask[ssm_pkg::BIT_DC] = dc_input_low;
      set_mask[ssm_pkg::BIT_SAG] = line_sag_event;
      next_flags = flags;
      if (wr_en && sfr_addr == ssm_pkg::ADDR_IRQ_FLAGS)
         next_flags = flags & sfr_wdata;
      next_flags = (next_flags | set_mask) & ssm_pkg::FLAG_MASK;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         flags <= ssm_pkg::RST_ZERO;
      else
         flags <= next_flags;
   end

   // ---------------------------------------------------------------
   // shared interrupt
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         supply_monitor_interrupt <= 1'b0;
      else
         supply_monitor_interrupt <= ie_prio_two[ssm_pkg::BIT_GLOBAL_EN]
            & ((|(flags[5:0] & irq_enable[5:0]))
            | (flags[ssm_pkg::BIT_RESTORE]
            & irq_enable[ssm_pkg::BIT_SWO]));
   end

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         sfr_rdata <= ssm_pkg::RST_ZERO;
      else if (sfr_read)
      begin
         case (sfr_addr)
            ssm_pkg::ADDR_IE_PRIO_TWO: sfr_rdata <= ie_prio_two;
            ssm_pkg::ADDR_BAT_RESULT: sfr_rdata <= bat_latched;
            ssm_pkg::ADDR_IRQ_ENABLE: sfr_rdata <= irq_enable;
            ssm_pkg::ADDR_DELTA: sfr_rdata <= delta;
            ssm_pkg::ADDR_PERIPHERAL_CONFIG_CFG:
            begin
               sfr_rdata <= peripheral_config_cfg;
               sfr_rdata[ssm_pkg::BIT_SOURCE] <= ~on_battery;
            end
            ssm_pkg::ADDR_SWO_CFG: sfr_rdata <= swo_cfg;
            ssm_pkg::ADDR_IRQ_FLAGS: sfr_rdata <= flags;
            ssm_pkg::ADDR_BAT_THRESH: sfr_rdata <= bat_thresh;
            ssm_pkg::ADDR_INT_PIN_CFG: sfr_rdata <= int_pin_cfg;
            default: sfr_rdata <= ssm_pkg::RST_ZERO;
         endcase
      end
   end
endmodule
`default_nettype wire

// ===== bench/ssm_core_model.sv
// core model: register master of the monitor, also drives the request pin
`timescale 1ns/1ps
`default_nettype none
module ssm_core_model
(
   input wire logic ref_clk,
   output logic [7:0] sfr_addr,
   output logic sfr_write,
   output logic sfr_read,
   output logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   output logic battery_request_pin
);
   initial
   begin
      {sfr_addr, sfr_wdata, sfr_write, sfr_read} = '0;
      battery_request_pin = 1'b0;
   end
   // idle address and data are inverted so a stale value never looks valid
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] q);
      @(posedge ref_clk);
      #1;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_write = w;
      sfr_read = !w;
      @(posedge ref_clk);
      #1;
      q = sfr_rdata;
      sfr_write = 1'b0;
      sfr_read = 1'b0;
      sfr_addr = ~a;
      sfr_wdata = ~d;
   endtask
   task automatic set_pin(input logic v);
      @(posedge ref_clk);
      #1;
      battery_request_pin = v;
   endtask
endmodule
`default_nettype wire

// ===== bench/ssm_monitor_assertions.sv
// checker: timing properties at the supply monitor ports
`timescale 1ns/1ps
`default_nettype none
module ssm_monitor_checker
#(
   parameter int QUAL_COUNT = 8,
   parameter int MEAS_COUNT = 16
)
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_write,
   input wire logic sfr_read,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic main_low,
   input wire logic main_recovered,
   input wire logic battery_request_pin,
   input wire logic use_battery,
   input wire logic supply_monitor_interrupt,
   input wire logic conversion_start
);
   logic [7:0] cfg;
   logic [1:0] pin_fn;
   logic gen;
   int good_cnt;
   // shadow copies of control registers as the core writes them
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         cfg <= ssm_pkg::RST_SELECT;
         pin_fn <= 2'b00;
         gen <= 1'b0;
      end
      else if (sfr_write && sfr_addr == ssm_pkg::ADDR_SWO_CFG)
         cfg <= sfr_wdata;
      else if (sfr_write && sfr_addr == ssm_pkg::ADDR_INT_PIN_CFG)
         pin_fn <= sfr_wdata[3:2];
      else if (sfr_write && sfr_addr == ssm_pkg::ADDR_IE_PRIO_TWO)
         gen <= sfr_wdata[5];
   end
   always_ff @(posedge ref_clk)
      good_cnt <= (main_recovered && !reset) ? good_cnt + 1 : 0;
   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   a_source_bit: assert property (sfr_read &&
      sfr_addr == ssm_pkg::ADDR_PERIPHERAL_CONFIG_CFG |=>
      sfr_rdata[6] == !use_battery) else $error("source bit wrong");
   a_main_switch: assert property (main_low && !cfg[1] && !cfg[3]
      |-> ##[0:3] use_battery) else $error("no switch on main low");
   a_pin_switch: assert property ($rose(battery_request_pin) &&
      pin_fn == 2'b01 && !cfg[1] |-> ##[0:3] use_battery)
      else $error("no switch on request pin");
   a_switch_off: assert property (cfg[1] ##2 cfg[1] |->
      !use_battery) else $error("battery used while disabled");
   a_return_wait: assert property ($fell(use_battery) &&
      !cfg[1] && !cfg[3] |-> good_cnt >= QUAL_COUNT - 1)
      else $error("return before recovery time");
   a_return_pin: assert property ($fell(use_battery) &&
      pin_fn == 2'b01 && !cfg[1] |-> !$past(battery_request_pin, 2))
      else $error("return while pin high");
   a_global_gate: assert property (!gen ##1 !gen |->
      !supply_monitor_interrupt) else $error("interrupt while off");
   a_start_write: assert property (sfr_write &&
      sfr_addr == ssm_pkg::ADDR_ADC_START |-> ##[1:2] conversion_start)
      else $error("no conversion after start write");
   c_to_battery: cover property ($rose(use_battery));
   c_to_main: cover property ($fell(use_battery));
   c_irq: cover property ($rose(supply_monitor_interrupt));
endmodule
bind ssm_supply_monitor ssm_monitor_checker #(.QUAL_COUNT(QUAL_COUNT),
   .MEAS_COUNT(MEAS_COUNT)) checker_inst (.ref_clk(ref_clk), .reset(reset),
   .sfr_addr(sfr_addr), .sfr_write(sfr_write), .sfr_read(sfr_read),
   .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .main_low(main_low),
   .main_recovered(main_recovered), .use_battery(use_battery),
   .battery_request_pin(battery_request_pin),
   .supply_monitor_interrupt(supply_monitor_interrupt),
   .conversion_start(conversion_start));
`default_nettype wire

// ===== bench/tb_top.sv
// testbench: register rows, then switchover and interrupt cases
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int QC = 8;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} ssm_row_type;
   logic ref_clk, reset, sfr_write, sfr_read, main_low, main_recovered;
   logic dc_input_low, dc_input_recovered, battery_request_pin, sag, vsw_v;
   logic bat_v, use_battery, irq, conv;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, q, vsw_res, bat_res;
   int fail_count = 0;
   int num_checks = 0;
   int cycles = 0;
   ssm_row_type rows [7] = '{'{ssm_pkg::ADDR_IRQ_ENABLE, 8'hff, 8'h6f},
      '{ssm_pkg::ADDR_IE_PRIO_TWO, 8'h20, 8'h20},
      '{ssm_pkg::ADDR_DELTA, 8'h5a, 8'h5a},
      '{ssm_pkg::ADDR_BAT_THRESH, 8'ha5, 8'ha5},
      '{ssm_pkg::ADDR_INT_PIN_CFG, 8'h04, 8'h04}, '{8'h10, 8'h55, 8'h00},
      '{ssm_pkg::ADDR_SWO_CFG, 8'h00, 8'h00}};
   ssm_supply_monitor #(.QUAL_COUNT(QC), .MEAS_COUNT(16))
      ssm_supply_monitor_inst (.ref_clk(ref_clk), .reset(reset),
      .sfr_addr(sfr_addr), .sfr_write(sfr_write), .sfr_read(sfr_read),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .main_low(main_low),
      .main_recovered(main_recovered), .dc_input_low(dc_input_low),
      .dc_input_recovered(dc_input_recovered), .line_sag_event(sag),
      .battery_request_pin(battery_request_pin), .vsw_result_valid(vsw_v),
      .vsw_result(vsw_res), .bat_result_valid(bat_v), .bat_result(bat_res),
      .use_battery(use_battery), .supply_monitor_interrupt(irq),
      .conversion_start(conv));
   ssm_core_model ssm_core_model_inst (.ref_clk(ref_clk),
      .sfr_addr(sfr_addr), .sfr_write(sfr_write), .sfr_read(sfr_read),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .battery_request_pin(battery_request_pin));
   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // a hang is cut short well beyond the fewer than 150 cycles the run needs
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         fail_count++;
         stop_test();
      end
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("wrong value at %0t ns: got %h, want %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      ssm_core_model_inst.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] m,
      input logic [7:0] e);
      ssm_core_model_inst.xfer(1'b0, a, 8'h00, q);
      chk(q & m, e);
   endtask
   task automatic src(input logic v, input int n);
      repeat (n)
      begin
         if (use_battery !== v)
         begin
            @(posedge ref_clk);
            #1;
         end
      end
      #1 chk({7'h00, use_battery}, {7'h00, v});
   endtask
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial
   begin
      {reset, main_low, main_recovered, dc_input_low} = 4'b1010;
      {dc_input_recovered, sag, vsw_v, bat_v} = 4'b1000;
      {vsw_res, bat_res} = 16'h0000;
      repeat (3) @(posedge ref_clk);
      #1 reset = 1'b0;
      rd(ssm_pkg::ADDR_SWO_CFG, 8'hff, 8'h0c);
      rd(ssm_pkg::ADDR_PERIPHERAL_CONFIG_CFG, 8'h40, 8'h40);
      chk({7'h00, irq}, 8'h00);
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, 8'hff, rows[i].e);
      end
      wr(ssm_pkg::ADDR_IRQ_FLAGS, 8'h00);
      {main_low, main_recovered} = 2'b10;
      src(1'b1, 6);
      rd(ssm_pkg::ADDR_PERIPHERAL_CONFIG_CFG, 8'h40, 8'h00);
      {main_low, main_recovered} = 2'b01;
      repeat (QC - 3) @(posedge ref_clk);
      #1 chk({7'h00, use_battery}, 8'h01);
      src(1'b0, 12);
      rd(ssm_pkg::ADDR_IRQ_FLAGS, 8'h42, 8'h42);
      chk({7'h00, irq}, 8'h01);
      wr(ssm_pkg::ADDR_IRQ_FLAGS, 8'hbd);
      rd(ssm_pkg::ADDR_IRQ_FLAGS, 8'h42, 8'h00);
      {dc_input_low, dc_input_recovered} = 2'b10;
      src(1'b1, 6);
      rd(ssm_pkg::ADDR_IRQ_FLAGS, 8'h01, 8'h01);
      {dc_input_low, dc_input_recovered} = 2'b01;
      src(1'b0, QC + 8);
      wr(ssm_pkg::ADDR_SWO_CFG, 8'h0c);
      ssm_core_model_inst.set_pin(1'b1);
      src(1'b1, 6);
      repeat (QC + 4) @(posedge ref_clk);
      #1 chk({7'h00, use_battery}, 8'h01);
      ssm_core_model_inst.set_pin(1'b0);
      src(1'b0, QC + 8);
      wr(ssm_pkg::ADDR_SWO_CFG, 8'h02);
      {main_low, main_recovered} = 2'b10;
      ssm_core_model_inst.set_pin(1'b1);
      repeat (6) @(posedge ref_clk);
      #1 chk({7'h00, use_battery}, 8'h00);
      {main_low, main_recovered} = 2'b01;
      ssm_core_model_inst.set_pin(1'b0);
      wr(ssm_pkg::ADDR_IRQ_FLAGS, 8'h00);
      wr(ssm_pkg::ADDR_IRQ_ENABLE, 8'h00);
      {vsw_res, bat_res} = 16'h3c21;
      {sag, vsw_v, bat_v} = 3'b111;
      @(posedge ref_clk);
      #1 {sag, vsw_v, bat_v} = 3'b000;
      rd(ssm_pkg::ADDR_IRQ_FLAGS, 8'h2c, 8'h2c);
      chk({7'h00, irq}, 8'h00);
      wr(ssm_pkg::ADDR_IRQ_ENABLE, 8'h08);
      wr(ssm_pkg::ADDR_IE_PRIO_TWO, 8'h00);
      wr(ssm_pkg::ADDR_ADC_START, 8'h01);
      chk({7'h00, conv}, 8'h01);
      chk({7'h00, irq}, 8'h00);
      wr(ssm_pkg::ADDR_IE_PRIO_TWO, 8'h20);
      rd(ssm_pkg::ADDR_IRQ_FLAGS, 8'h08, 8'h08);
      chk({7'h00, irq}, 8'h01);
      rd(ssm_pkg::ADDR_BAT_RESULT, 8'hff, 8'h21);
      wr(ssm_pkg::ADDR_IRQ_FLAGS, 8'h00);
      rd(ssm_pkg::ADDR_IRQ_FLAGS, 8'h04, 8'h04);
      wr(ssm_pkg::ADDR_BAT_THRESH, 8'h10);
      wr(ssm_pkg::ADDR_IRQ_FLAGS, 8'h00);
      rd(ssm_pkg::ADDR_IRQ_FLAGS, 8'hff, 8'h00);
      // reset in mid-run while on battery with the request pin still high
      wr(ssm_pkg::ADDR_SWO_CFG, 8'h0c);
      ssm_core_model_inst.set_pin(1'b1);
      src(1'b1, 6);
      reset = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1 reset = 1'b0;
      chk({7'h00, use_battery}, 8'h00);
      rd(ssm_pkg::ADDR_SWO_CFG, 8'hff, 8'h0c);
      rd(ssm_pkg::ADDR_IRQ_FLAGS, 8'hff, 8'h00);
      rd(ssm_pkg::ADDR_IE_PRIO_TWO, 8'hff, 8'h00);
      chk({7'h00, irq}, 8'h00);
      ssm_core_model_inst.set_pin(1'b0);
      src(1'b0, 4);
      stop_test();
   end
endmodule
`default_nettype wire
